//--- core/sca_pkg.sv
/*
 * Constants for the shadow, cache and AT-bus configuration bank.
 * Assumes a single 100 MHz core clock and an 8-bit register port.
 */
package sca_pkg;
    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] SCA_OFF_SHADOW = 8'h26; // shadow_rom_control_three
    localparam logic [7:0] SCA_OFF_CTRL = 8'h27; // cache_at_bus_control
    localparam logic [7:0] SCA_OFF_BLK1 = 8'h28; // uncached_block_one_config
    localparam logic [7:0] SCA_OFF_STATUS = 8'h40; // live state, read only

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] SCA_RST_SHADOW = 8'h10;
    localparam logic [7:0] SCA_RST_CTRL = 8'hdf;
    localparam logic [7:0] SCA_RST_BLK1 = 8'he0;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int SCA_SH_ROMWR = 7;
    localparam int SCA_SH_COPY = 6;
    localparam int SCA_SH_WPROT = 5;
    localparam int SCA_SH_SMMBURST = 4;
    localparam int SCA_SH_SEG_HI = 3;
    localparam int SCA_CT_NOCACHE = 7;
    localparam int SCA_CT_FASTAT = 6;
    localparam int SCA_CT_NOIODLY = 5;
    localparam int SCA_CT_TURBO = 3;
    localparam int SCA_CT_WTHRU = 2;
    localparam int SCA_CT_SYNCCLK = 1;
    localparam int SCA_BK_TYPE_HI = 7;
    localparam int SCA_BK_SIZE_HI = 6;
    localparam int SCA_BK_SIZE_LO = 5;
    localparam int SCA_BK_TYPE_LO = 4;
    localparam int SCA_BK_NEWDRAM = 3;
    localparam int SCA_BK_ADDR_HI = 2;

    // ----------------------------------------------------------------
    // Block 1 encodings
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        SCA_HOLE_ISA = 2'h0,
        SCA_HOLE_ROM = 2'h1,
        SCA_HOLE_NONE = 2'h2,
        SCA_HOLE_DRAM = 2'h3
    } sca_hole_t;
    localparam logic [1:0] SCA_SIZE_64K = 2'h0;
    localparam logic [1:0] SCA_SIZE_128K = 2'h1;
    localparam logic [1:0] SCA_SIZE_256K = 2'h2;
    localparam logic [1:0] SCA_SIZE_1M = 2'h3;

    // ----------------------------------------------------------------
    // Address map, in 64KB units of A[26:16]
    // ----------------------------------------------------------------
    localparam logic [10:0] SCA_SEG_C = 11'h00c;
    localparam logic [10:0] SCA_SEG_E = 11'h00e;
    localparam logic [10:0] SCA_SEG_F = 11'h00f;

    // ----------------------------------------------------------------
    // AT-cycle timing, in AT bus clocks
    // ----------------------------------------------------------------
    localparam logic [1:0] SCA_ALE_DLY_NORMAL = 2'h2;
    localparam logic [1:0] SCA_ALE_DLY_FAST = 2'h1;
    localparam logic [1:0] SCA_IO_RECOVERY = 2'h3;
endpackage

//--- core/sca_region_decode.sv
/*
 * Combinational decode of a memory address against the shadow and
 * non-cacheable block 1 settings. Caller registers the results.
 */
`timescale 1ns/100ps
`default_nettype none
module sca_region_decode
    import sca_pkg::*;
(
    input wire logic [26:0] addr,
    input wire logic [3:0] seg_enable,
    input wire logic [2:0] blk_upper,
    input wire logic [7:0] blk_mid,
    input wire logic [1:0] blk_size,
    input wire logic [1:0] blk_type,
    output logic in_copy_area,
    output logic in_prot_area,
    output logic seg_shadowed,
    output logic in_rom_space,
    output logic hole_hit
);
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Compare mask of 64KB units; low unit bits ignored by block size
    function automatic logic [10:0] size_mask(input logic [1:0] sz);
        unique case (sz)
            SCA_SIZE_64K: size_mask = 11'h7ff;
            SCA_SIZE_128K: size_mask = 11'h7fe;
            SCA_SIZE_256K: size_mask = 11'h7fc;
            SCA_SIZE_1M: size_mask = 11'h7f0;
        endcase
    endfunction

    logic [10:0] unit; // Address in 64KB units
    logic [10:0] base; // Block 1 start in 64KB units
    logic [10:0] mask;

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    always_comb
    begin
        unit = addr[26:16];
        base = {blk_upper, blk_mid};
        mask = size_mask(blk_size);
        // Copy window spans C, D and E segments
        in_copy_area = (unit >= SCA_SEG_C) && (unit <= SCA_SEG_E);
        in_prot_area = (unit == SCA_SEG_C);
        // One enable bit per 16KB slice of segment C
        seg_shadowed = in_prot_area && seg_enable[addr[15:14]];
        in_rom_space = (unit >= SCA_SEG_E) && (unit <= SCA_SEG_F);
        // Unaligned bases simply lose their low bits here
        hole_hit = (blk_type != SCA_HOLE_NONE)
            && ((unit & mask) == (base & mask));
    end
endmodule
`default_nettype wire

//--- core/sca_at_clock.sv
/*
 * AT bus clock source: oscillator/2 or the synchronous divided clock.
 * Assumes osc_level is already synchronised to clock.
 */
`timescale 1ns/100ps
`default_nettype none
module sca_at_clock
    import sca_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic osc_level,
    input wire logic sync_div_clock,
    input wire logic use_osc,
    output logic at_bus_clock,
    output logic at_rise
);
    logic osc_prev; // Last oscillator level
    logic osc_half; // Oscillator divided by two

    // ----------------------------------------------------------------
    // Oscillator halving
    // ----------------------------------------------------------------
    // Toggle on each oscillator rising edge
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            osc_prev <= 1'b0;
            osc_half <= 1'b0;
        end
        else
        begin
            osc_prev <= osc_level;
            if (osc_level && !osc_prev)
                osc_half <= ~osc_half;
        end
    end

    // ----------------------------------------------------------------
    // Source select and edge flag
    // ----------------------------------------------------------------
    // Switch is not glitch-free; a short AT phase may occur on change
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            at_bus_clock <= 1'b0;
            at_rise <= 1'b0;
        end
        else
        begin
            at_bus_clock <= use_osc ? osc_half : sync_div_clock;
            at_rise <= (use_osc ? osc_half : sync_div_clock) && !at_bus_clock;
        end
    end
endmodule
`default_nettype wire

//--- core/sca_config_bank.sv
/*
 * Shadow RAM, cache and AT-bus configuration bank with the logic the
 * three registers steer. Assumes a plain register port on clock and
 * that all CPU and ISA side pins are asynchronous to clock.
 */
`timescale 1ns/100ps
`default_nettype none
module sca_config_bank
    import sca_pkg::*;
#(
    parameter int SYNC_W = 36
)
(
    input wire logic clock,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [26:0] mem_addr,
    input wire logic mem_read,
    input wire logic mem_write,
    input wire logic cpu_address_strobe_n,
    input wire logic at_cycle,
    input wire logic io_cycle,
    input wire logic system_management_mode,
    input wire logic modified_line_hit_n,
    input wire logic refresh_req,
    input wire logic power_mgmt_mode,
    input wire logic oscillator_input,
    input wire logic sync_div_clock,
    input wire logic [7:0] blk_mid_addr,
    output logic rom_chip_select_n,
    output logic isa_rom_read,
    output logic shadow_dram_write,
    output logic shadow_dram_read,
    output logic shadow_write_blocked,
    output logic cpu_cacheable,
    output logic burst_last_signal_n,
    output logic hold_request,
    output logic burst_write_allow,
    output logic modified_hit_seen,
    output logic at_bus_clock,
    output logic isa_addr_latch_en,
    output logic at_busy,
    output logic dram_config_new
);
    // ----------
    // Declarations
    // ----------
    typedef enum logic [1:0] {
        SCA_AT_IDLE,
        SCA_AT_DELAY,
        SCA_AT_LATCH,
        SCA_AT_RECOVER
    } sca_at_state_t;

    logic [7:0] shadow_rom_control_three; // Shadow and ROM control
    logic [7:0] cache_at_bus_control; // Cache and AT timing
    logic [7:0] uncached_block_one_config; // Block 1 type, size, base
    logic [SYNC_W-1:0] pin_meta; // First sync stage, read by stage two only
    logic [SYNC_W-1:0] pin_sync; // Second sync stage
    logic [26:0] s_addr;
    logic s_rd, s_wr, s_ads_n, s_at, s_io, s_smm, s_modified_line_hit_n, s_refr, s_pm, s_osc;
    logic ads_prev; // Previous strobe level
    logic refr_prev; // Previous refresh level
    logic refresh_odd; // Alternates each refresh
    logic in_copy_area, in_prot_area, seg_shadowed, in_rom_space, hole_hit;
    logic at_rise; // One-cycle AT clock rising edge
    sca_at_state_t at_state;
    logic [1:0] at_count; // AT clocks left in the phase
    logic at_is_io; // Current AT cycle is I/O
    logic [1:0] next_ale_delay;
    logic use_osc;
    // ----------
    // Register writes
    // ----------
    // Bit 0 and reserved bit 4 of control are plain storage
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            shadow_rom_control_three <= SCA_RST_SHADOW;
            cache_at_bus_control <= SCA_RST_CTRL;
            uncached_block_one_config <= SCA_RST_BLK1;
        end
        else if (reg_wr)
        begin
            unique case (reg_addr)
                SCA_OFF_SHADOW: shadow_rom_control_three <= reg_wdata;
                SCA_OFF_CTRL: cache_at_bus_control <= reg_wdata;
                SCA_OFF_BLK1: uncached_block_one_config <= reg_wdata;
                default: ; // Unmapped and read-only writes ignored
            endcase
        end
    end
    // ----------
    // Register reads
    // ----------
    // Data stand only in the cycle after the strobe
    always_ff @(posedge clock)
    begin
        if (rst || !reg_rd)
            reg_rdata <= 8'h00;
        else
        begin
            unique case (reg_addr)
                SCA_OFF_SHADOW: reg_rdata <= shadow_rom_control_three;
                SCA_OFF_CTRL: reg_rdata <= cache_at_bus_control;
                SCA_OFF_BLK1: reg_rdata <= uncached_block_one_config;
                // Live state so software can see what the block does
                SCA_OFF_STATUS: reg_rdata <= {at_busy, hold_request,
                    modified_hit_seen, use_osc, s_smm, 1'b0, at_state};
                default: reg_rdata <= 8'h00;
            endcase
        end
    end
    // ----------
    // Pin synchronisers
    // ----------
    // Address settles before the strobe; per-bit skew is harmless
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            pin_meta <= '0;
            pin_sync <= '0;
        end
        else
        begin
            pin_meta <= {mem_addr, mem_read, mem_write, cpu_address_strobe_n,
                at_cycle, io_cycle, system_management_mode,
                modified_line_hit_n, refresh_req, power_mgmt_mode};
            pin_sync <= pin_meta;
        end
    end
    // Oscillator uses its own pair; it toggles independently
    logic osc_meta;
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            osc_meta <= 1'b0;
            s_osc <= 1'b0;
        end
        else
        begin
            osc_meta <= oscillator_input;
            s_osc <= osc_meta;
        end
    end
    // Unpack synchronised pins
    assign {s_addr, s_rd, s_wr, s_ads_n, s_at, s_io, s_smm,
        s_modified_line_hit_n, s_refr, s_pm} = pin_sync;
    // ----------
    // Address decode
    // ----------
    sca_region_decode u_decode (
        .addr(s_addr),
        .seg_enable(shadow_rom_control_three[SCA_SH_SEG_HI:0]),
        .blk_upper(uncached_block_one_config[SCA_BK_ADDR_HI:0]),
        .blk_mid(blk_mid_addr),
        .blk_size(uncached_block_one_config[SCA_BK_SIZE_HI:SCA_BK_SIZE_LO]),
        .blk_type({uncached_block_one_config[SCA_BK_TYPE_HI],
            uncached_block_one_config[SCA_BK_TYPE_LO]}),
        .in_copy_area(in_copy_area),
        .in_prot_area(in_prot_area),
        .seg_shadowed(seg_shadowed),
        .in_rom_space(in_rom_space),
        .hole_hit(hole_hit)
    );
    // ----------
    // Shadow and ROM steering
    // ----------
    // Copy mode wins over a shadowed read so ROM refills the DRAM
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            rom_chip_select_n <= 1'b1;
            isa_rom_read <= 1'b0;
            shadow_dram_write <= 1'b0;
            shadow_dram_read <= 1'b0;
            shadow_write_blocked <= 1'b0;
        end
        else
        begin
            // Reads of ROM space always select ROM; writes only when enabled
            rom_chip_select_n <= !((s_rd && in_rom_space && !seg_shadowed)
                || (s_wr && in_rom_space
                    && shadow_rom_control_three[SCA_SH_ROMWR]));
            // ROM read on ISA, same data captured into DRAM
            isa_rom_read <= s_rd && in_copy_area
                && shadow_rom_control_three[SCA_SH_COPY];
            shadow_dram_write <= (s_rd && in_copy_area
                    && shadow_rom_control_three[SCA_SH_COPY])
                || (s_wr && seg_shadowed
                    && !shadow_rom_control_three[SCA_SH_WPROT]);
            shadow_dram_read <= s_rd && seg_shadowed
                && !shadow_rom_control_three[SCA_SH_COPY];
            shadow_write_blocked <= s_wr && in_prot_area
                && shadow_rom_control_three[SCA_SH_WPROT];
        end
    end
    // ----------
    // Cache and CPU bus control
    // ----------
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            cpu_cacheable <= 1'b0;
            burst_last_signal_n <= 1'b1;
            burst_write_allow <= 1'b0;
            modified_hit_seen <= 1'b0;
            dram_config_new <= 1'b0;
        end
        else
        begin
            // Global switch is active low; block 1 hole never caches
            cpu_cacheable <= !cache_at_bus_control[SCA_CT_NOCACHE]
                && !hole_hit;
            // Force burst-last in SYSTEM_MANAGEMENT_MODE when bursts are disabled
            burst_last_signal_n <= !(s_smm
                && !shadow_rom_control_three[SCA_SH_SMMBURST]);
            burst_write_allow <= !cache_at_bus_control[SCA_CT_WTHRU];
            // Hit input is ignored in write-through mode
            modified_hit_seen <= !cache_at_bus_control[SCA_CT_WTHRU]
                && !s_modified_line_hit_n;
            dram_config_new <= uncached_block_one_config[SCA_BK_NEWDRAM];
        end
    end
    // ----------
    // Refresh hold in slow mode
    // ----------
    // Hold stands for the length of every second refresh request
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            refr_prev <= 1'b0;
            refresh_odd <= 1'b0;
            hold_request <= 1'b0;
        end
        else
        begin
            refr_prev <= s_refr;
            if (s_refr && !refr_prev)
                refresh_odd <= ~refresh_odd;
            hold_request <= s_refr && refresh_odd
                && !cache_at_bus_control[SCA_CT_TURBO];
        end
    end
    // ----------
    // AT bus clock
    // ----------
    assign use_osc = s_pm || !cache_at_bus_control[SCA_CT_SYNCCLK];
    sca_at_clock u_at_clock (
        .clock(clock),
        .rst(rst),
        .osc_level(s_osc),
        .sync_div_clock(sync_div_clock),
        .use_osc(use_osc),
        .at_bus_clock(at_bus_clock),
        .at_rise(at_rise)
    );
    // ----------
    // AT cycle sequencer
    // ----------
    // Latch delay taken from the fast-cycle bit at strobe time
    assign next_ale_delay = cache_at_bus_control[SCA_CT_FASTAT]
        ? SCA_ALE_DLY_FAST : SCA_ALE_DLY_NORMAL;
    // Strobes while busy are dropped; the CPU side waits for idle
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            ads_prev <= 1'b1;
            at_state <= SCA_AT_IDLE;
            at_count <= 2'h0;
            at_is_io <= 1'b0;
            isa_addr_latch_en <= 1'b0;
            at_busy <= 1'b0;
        end
        else
        begin
            ads_prev <= s_ads_n;
            unique case (at_state)
                SCA_AT_IDLE:
                begin
                    if (!s_ads_n && ads_prev && s_at)
                    begin
                        at_state <= SCA_AT_DELAY;
                        at_count <= next_ale_delay;
                        at_is_io <= s_io;
                        at_busy <= 1'b1;
                    end
                end
                SCA_AT_DELAY:
                begin
                    if (at_rise)
                    begin
                        if (at_count == 2'h1)
                        begin
                            at_state <= SCA_AT_LATCH;
                            isa_addr_latch_en <= 1'b1;
                        end
                        at_count <= at_count - 2'h1;
                    end
                end
                SCA_AT_LATCH:
                begin
                    // Latch enable lasts one AT clock
                    if (at_rise)
                    begin
                        isa_addr_latch_en <= 1'b0;
                        if (at_is_io && !cache_at_bus_control[SCA_CT_NOIODLY])
                        begin
                            at_state <= SCA_AT_RECOVER;
                            at_count <= SCA_IO_RECOVERY;
                        end
                        else
                        begin
                            at_state <= SCA_AT_IDLE;
                            at_busy <= 1'b0;
                        end
                    end
                end
                SCA_AT_RECOVER:
                begin
                    // Three AT clocks before the next I/O may start
                    if (at_rise)
                    begin
                        if (at_count == 2'h1)
                        begin
                            at_state <= SCA_AT_IDLE;
                            at_busy <= 1'b0;
                        end
                        at_count <= at_count - 2'h1;
                    end
                end
            endcase
        end
    end
endmodule
`default_nettype wire

//--- tb/sca_config_bank_assertions.sv
/* Port checker for the configuration bank.
   Assumes bind to sca_config_bank; registers are mirrored from writes. */
`timescale 1ns/100ps
`default_nettype none
module sca_config_bank_assertions
    import sca_pkg::*;
(
    input wire logic clock, rst, reg_wr, mem_read, mem_write,
    input wire logic [7:0] reg_addr, reg_wdata,
    input wire logic [26:0] mem_addr,
    input wire logic system_management_mode, power_mgmt_mode, at_bus_clock,
    input wire logic rom_chip_select_n, shadow_write_blocked, shadow_dram_write,
    input wire logic cpu_cacheable, burst_last_signal_n, hold_request,
    input wire logic burst_write_allow, modified_hit_seen, dram_config_new
);
    // ----------
    // Register mirrors
    // ----------
    logic [7:0] sh, ct, bk; // Shadow, control, block 1 copies
    // Follow writes so rules can be judged from ports alone
    always_ff @(posedge clock)
    begin
        if (rst) {sh, ct, bk} <= {SCA_RST_SHADOW, SCA_RST_CTRL, SCA_RST_BLK1};
        else if (reg_wr && reg_addr == SCA_OFF_SHADOW) sh <= reg_wdata;
        else if (reg_wr && reg_addr == SCA_OFF_CTRL) ct <= reg_wdata;
        else if (reg_wr && reg_addr == SCA_OFF_BLK1) bk <= reg_wdata;
    end
    // ----------
    // Properties; windows cover 2FF sync plus output flop
    // ----------
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    sequence s_smm_no_burst; (system_management_mode && !sh[4])[*5]; endsequence
    sequence s_pm_edge; power_mgmt_mode[*8] ##0 $changed(at_bus_clock); endsequence
    property p_rom_wr; (mem_write && !mem_read && mem_addr[26:17] == 10'h007
        && $stable(mem_addr) && $stable(sh))[*5] |-> rom_chip_select_n == !sh[7]; endproperty
    a_rom_wr: assert property (p_rom_wr) else $error("rom select wrong");
    property p_wprot; (mem_write && mem_addr[26:16] == SCA_SEG_C && sh[5]
        && $stable(mem_addr))[*5] |-> shadow_write_blocked && !shadow_dram_write; endproperty
    a_wprot: assert property (p_wprot) else $error("protected write passed");
    property p_smm; s_smm_no_burst |-> !burst_last_signal_n; endproperty
    a_smm: assert property (p_smm) else $error("burst not stopped");
    property p_nocache; ct[7][*3] |-> !cpu_cacheable; endproperty
    a_nocache: assert property (p_nocache) else $error("cacheable while off");
    property p_turbo; ct[3][*4] |-> !hold_request; endproperty
    a_turbo: assert property (p_turbo) else $error("hold in fast mode");
    property p_wthru; ct[2][*3] |-> !burst_write_allow && !modified_hit_seen; endproperty
    a_wthru: assert property (p_wthru) else $error("write-back in wt mode");
    property p_pm_clk; s_pm_edge |=> $stable(at_bus_clock)[*3]; endproperty
    a_pm_clk: assert property (p_pm_clk) else $error("at clock not osc/2");
    property p_dcfg; bk[3] == $past(bk[3]) |-> dram_config_new == bk[3]; endproperty
    a_dcfg: assert property (p_dcfg) else $error("dram config select");
endmodule
bind sca_config_bank sca_config_bank_assertions u_chk (.*);
`default_nettype wire

//--- tb/sca_pin_model.sv
/* Far-side clock sources: oscillator pin and the divided AT clock.
   Assumes a 100 MHz core clock feeding the divider. */
`timescale 1ns/100ps
`default_nettype none
module sca_pin_model
(
    input wire logic clock,
    output logic oscillator_input,
    output logic sync_div_clock
);
    logic [1:0] div_cnt = 2'h0; // Divide-by-three phase
    logic div_q = 1'b0; // Divided clock level
    assign sync_div_clock = div_q;
    // 25 MHz oscillator, edges kept clear of core clock edges
    initial
    begin
        oscillator_input = 1'b0;
        #2;
        forever #20 oscillator_input = ~oscillator_input;
    end
    // Divided clock toggles every third core clock, period 6
    always @(posedge clock)
    begin
        div_cnt <= (div_cnt == 2'h2) ? 2'h0 : div_cnt + 2'h1;
        if (div_cnt == 2'h2) div_q <= ~div_q;
    end
endmodule
`default_nettype wire

//--- tb/sca_config_bank_tb.sv
/* Self-checking bench for the configuration bank.
   Drives register port and pins; sca_pin_model supplies the clocks. */
`timescale 1ns/100ps
`default_nettype none
module sca_config_bank_tb
    import sca_pkg::*;
;
    logic clock = 0, rst = 1, reg_wr = 0, reg_rd = 0, h;
    logic mem_read = 0, mem_write = 0, system_management_mode = 0, power_mgmt_mode = 0;
    logic refresh_req = 0, cpu_address_strobe_n = 1, at_cycle = 0, io_cycle = 0;
    logic modified_line_hit_n = 0, oscillator_input, sync_div_clock;
    logic [7:0] reg_addr = 0, reg_wdata = 0, blk_mid_addr = 8'h20, reg_rdata;
    logic [26:0] mem_addr = 0;
    logic rom_chip_select_n, isa_rom_read, shadow_dram_write, shadow_dram_read;
    logic shadow_write_blocked, cpu_cacheable, burst_last_signal_n, hold_request;
    logic burst_write_allow, modified_hit_seen, at_bus_clock, isa_addr_latch_en;
    logic at_busy, dram_config_new;
    int fail_count = 0, cmp_count = 0, cycles = 0, n, i;
    // Reset table, unmapped 30h last
    logic [7:0] ra [4] = '{8'h26, 8'h27, 8'h28, 8'h30};
    logic [7:0] rv [4] = '{SCA_RST_SHADOW, SCA_RST_CTRL, SCA_RST_BLK1, 8'h00};
    // Block 1 cases: all types, sizes, hole edges; bases aligned
    logic [7:0] hb [9] = '{8'h91, 8'h91, 8'hb1, 8'hd1, 8'hf1, 8'he1, 8'h01, 8'h11, 8'h92};
    logic [26:0] ha [9] = '{27'h1200000, 27'h1210000, 27'h1210000, 27'h1230000,
        27'h12f0000, 27'h1200000, 27'h1200000, 27'h1200000, 27'h1200000};
    logic he [9] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
    logic [7:0] cv [3] = '{8'h5f, 8'h5d, 8'h5f}; // Sync, osc, sync setting with power mode forcing osc
    int ev [3] = '{40, 30, 30}; // AT clock rises per 240 cycles
    sca_config_bank uut (.*);
    sca_pin_model u_pins (.clock(clock), .oscillator_input(oscillator_input),
        .sync_div_clock(sync_div_clock));
    always #5 clock = ~clock;
    // ----------
    // Tasks
    // ----------
    task automatic chk(input logic [7:0] g, e);
        cmp_count++;
        if (g !== e) $display("[ERR] %0t got %h want %h", $time, g, e);
        fail_count += int'(g !== e);
    endtask
    // One strobe cycle; a read checks data in the following cycle
    task automatic acc(input logic w, input logic [7:0] a, d);
        @(posedge clock);
        {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, d};
        @(posedge clock);
        {reg_wr, reg_rd} <= 2'h0;
        #1 if (!w) chk(reg_rdata, d);
    endtask
    // Pins: read, write, smm, power mode; settle past the synchronisers
    task automatic mem(input logic [26:0] a, input logic [3:0] f);
        @(posedge clock);
        mem_addr <= a;
        {mem_read, mem_write, system_management_mode, power_mgmt_mode} <= f;
        repeat (5) @(posedge clock);
        #1;
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Hang guard
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            fail_count++;
            final_report;
        end
    end
    // ----------
    // Sequence
    // ----------
    initial
    begin
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        foreach (ra[k]) acc(0, ra[k], rv[k]);
        acc(1, SCA_OFF_SHADOW, 8'h12);
        acc(0, SCA_OFF_SHADOW, 8'h12);
        mem(27'h00c4000, 4'h8);
        chk(shadow_dram_read, 1'b1);
        mem(27'h00c0000, 4'h8);
        chk(shadow_dram_read, 1'b0);
        acc(1, SCA_OFF_SHADOW, 8'h52);
        mem(27'h00e8000, 4'h8);
        chk({isa_rom_read, shadow_dram_write}, 2'h3);
        acc(1, SCA_OFF_SHADOW, 8'h30);
        mem(27'h00c8000, 4'h4);
        chk(shadow_write_blocked, 1'b1);
        acc(1, SCA_OFF_SHADOW, 8'h90);
        mem(27'h00f0000, 4'h4);
        chk(rom_chip_select_n, 1'b0);
        acc(1, SCA_OFF_SHADOW, 8'h00);
        mem(27'h0100000, 4'ha);
        chk(burst_last_signal_n, 1'b0);
        chk(cpu_cacheable, 1'b0);
        acc(1, SCA_OFF_CTRL, 8'h5b);
        foreach (hb[k])
        begin
            acc(1, SCA_OFF_BLK1, hb[k]);
            mem(ha[k], 4'h8);
            chk(cpu_cacheable, he[k]);
        end
        chk({burst_write_allow, modified_hit_seen}, 2'h3);
        acc(1, SCA_OFF_BLK1, 8'h08);
        mem(27'h0, 4'h0);
        chk(dram_config_new, 1'b1);
        acc(1, SCA_OFF_CTRL, 8'h57);
        for (i = 0; i < 4; i++)
        begin
            @(posedge clock);
            refresh_req <= 1'b1;
            repeat (6) @(posedge clock);
            #1 h = hold_request;
            @(posedge clock);
            refresh_req <= 1'b0;
            repeat (6) @(posedge clock);
            chk(h, 8'((i + 1) % 2));
        end
        // Fast I/O AT cycle: one AT clock to latch, three of recovery
        {at_cycle, io_cycle, cpu_address_strobe_n} <= 3'h6;
        n = 0;
        i = 0;
        repeat (60)
        begin
            @(posedge clock);
            #1 n += int'(at_busy);
            i += int'(isa_addr_latch_en);
        end
        chk(8'(i), 8'h6);
        chk(8'(n >= 25 && n <= 30), 8'h1);
        for (i = 0; i < 3; i++)
        begin
            acc(1, SCA_OFF_CTRL, cv[i]);
            mem(27'h0, {3'h0, i == 2});
            n = 0;
            repeat (240)
            begin
                h = at_bus_clock;
                @(posedge clock);
                #1 n += int'(at_bus_clock && !h);
            end
            chk(8'(n >= ev[i] - 1 && n <= ev[i] + 1), 8'h1);
        end
        final_report;
    end
endmodule
`default_nettype wire
